// [dcsm_top.sv]
// Purpose: control state machine of a networked servo drive
// Assumes: command word written through cmd_wr/cmd_data, inputs synchronous
// Notes:   transitions follow the last written command word each cycle
//
// Notes on behaviour
// - enabled plus quick stop enters quick stop
// - enabled plus shutdown returns to ready
// - enabled: disable voltage or enable loss disables
// - enabled plus switch on returns to switched on
// - enabled keeps power, loops and targets
// - quick stop decelerates then holds, power on
// - quick stop plus enable operation re-enables
// - quick stop disable goes through power delay
// - fault reaction dwells then enters fault
// - fault reaction keeps power and loops
// - fault state keeps power stage off
// - fault leaves only on reset fault
// - disable voltage: bit7 0, bit1 0
// - shutdown: bit7 0, bits2..0 110
// - switch on: bit7 0, bits3..0 0111
// - enable operation: bit7 0, bits3..0 1111
// - quick stop: bit7 0, bit2 0, bit1 1
// - homing runs on bit 4 in homing mode
// - bit 12 inhibits negative motion while the power stage is on
// - bit 13 inhibits positive motion while the power stage is on
// - power-up walks to switch on disabled
// - internal fault enters fault reaction
// - disabled/ready moves by shutdown, disable, quick stop
`timescale 1ns/1ps
`default_nettype none
`include "dcsm_defines.svh"

module dcsm_top #(
   parameter int unsigned FRA_CYC = `DCSM_FRA_DWELL_CYC,
   parameter int unsigned PDD_CYC = `DCSM_PDD_CYC,
   parameter int unsigned CNT_W   = 17
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    cmd_wr,
   input  wire logic [15:0]             cmd_data,
   input  wire logic                    drive_enable_in,
   input  wire logic                    fault_detect,
   input  wire logic                    homing_mode,
   input  wire logic                    position_mode,
   input  wire logic                    speed_zero,
   output var  dcsm_pkg::dcsm_state_t   state_q,
   output var  dcsm_pkg::dcsm_drive_out_t drive_out_q
);
   import dcsm_pkg::*;

   // ----------------------------------------------------------------
   // command word register and decode
   // ----------------------------------------------------------------
   logic [15:0]      drive_command_word_q;
   logic             b7_prev_q;
   dcsm_state_t      state_d;
   dcsm_drive_out_t  out_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   wire logic [15:0] cw = drive_command_word_q;
   wire logic b7  = cw[`DCSM_B_FAULT_RESET];
   wire logic b4  = cw[`DCSM_B_HOMING];
   wire logic b3  = cw[`DCSM_B_ENABLE_OP];
   wire logic b2  = cw[`DCSM_B_QSTOP_N];
   wire logic b1  = cw[`DCSM_B_VOLTAGE];
   wire logic b0  = cw[`DCSM_B_SWITCH_ON];

   wire logic cmd_dis_volt = !b7 && !b1;
   wire logic cmd_shutdown = !b7 && b2 && b1 && !b0;
   wire logic cmd_switchon = !b7 && !b3 && b2 && b1 && b0;
   wire logic cmd_enable   = !b7 && b3 && b2 && b1 && b0;
   wire logic cmd_qstop    = !b7 && !b2 && b1;
   // edge only, so a word left at 0x80 cannot clear a fault twice
   wire logic cmd_rst_flt  = b7 && !b7_prev_q;
   wire logic en_lost      = !drive_enable_in;

   wire logic fra_done = (cnt_q == CNT_W'(FRA_CYC - 1));
   wire logic pdd_done = (cnt_q == CNT_W'(PDD_CYC - 1));
   // boot states are not interrupted; a held fault is taken once DCSM_SW_ON_DIS is reached
   wire logic boot     = (state_q == DCSM_START) ||
                         (state_q == DCSM_NOT_READY);
   wire logic take_flt = fault_detect && !boot &&
                         (state_q != DCSM_FAULT_REACT) &&
                         (state_q != DCSM_FAULT);

   always_ff @(posedge clk) begin
      if (rst) begin
         drive_command_word_q <= `DCSM_CMD_RESET;
         b7_prev_q            <= 1'b0;
      end else begin
         if (cmd_wr) begin
            drive_command_word_q <= cmd_data;
         end
         b7_prev_q <= b7;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (take_flt) begin
         state_d = DCSM_FAULT_REACT;
      end else begin
         case (state_q)
            DCSM_START:      state_d = DCSM_NOT_READY;
            DCSM_NOT_READY:  state_d = DCSM_SW_ON_DIS;
            DCSM_SW_ON_DIS: begin
               if (cmd_shutdown) state_d = DCSM_READY;
            end
            DCSM_READY: begin
               if (cmd_dis_volt || cmd_qstop) begin
                  state_d = DCSM_SW_ON_DIS;
               end else if (cmd_switchon) begin
                  state_d = DCSM_SWITCHED;
               end
            end
            DCSM_SWITCHED: begin
               if (cmd_dis_volt || cmd_qstop) begin
                  state_d = DCSM_SW_ON_DIS;
               end else if (cmd_shutdown) begin
                  state_d = DCSM_READY;
               end else if (cmd_enable) begin
                  state_d = DCSM_OP_ENABLED;
               end
            end
            DCSM_OP_ENABLED: begin
               if (cmd_dis_volt || en_lost) begin
                  state_d = DCSM_SW_ON_DIS;
               end else if (cmd_qstop) begin
                  state_d = DCSM_QSTOP;
               end else if (cmd_shutdown) begin
                  state_d = DCSM_READY;
               end else if (cmd_switchon) begin
                  state_d = DCSM_SWITCHED;
               end
            end
            DCSM_QSTOP: begin
               if (cmd_dis_volt || en_lost) begin
                  state_d = DCSM_PWR_DELAY;
               end else if (cmd_enable) begin
                  state_d = DCSM_OP_ENABLED;
               end
            end
            DCSM_PWR_DELAY: begin
               if (pdd_done) state_d = DCSM_SW_ON_DIS;
            end
            DCSM_FAULT_REACT: begin
               if (fra_done) state_d = DCSM_FAULT;
            end
            DCSM_FAULT: begin
               if (cmd_rst_flt) state_d = DCSM_SW_ON_DIS;
            end
            default:         state_d = DCSM_START;
         endcase
      end
   end

   // dwell counter restarts on every state change
   assign cnt_d = (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);

   // ----------------------------------------------------------------
   // drive outputs, registered from the next state so they line up
   // ----------------------------------------------------------------
   wire logic n_oe   = (state_d == DCSM_OP_ENABLED);
   wire logic n_qs   = (state_d == DCSM_QSTOP);
   wire logic n_fra  = (state_d == DCSM_FAULT_REACT);
   wire logic n_pwr  = n_oe || n_qs || n_fra ||
                       (state_d == DCSM_SWITCHED) ||
                       (state_d == DCSM_PWR_DELAY);
   wire logic n_home = n_oe && homing_mode && b4 && b3 && b2 && b1 &&
                       b0 && !b7;

   always_comb begin
      out_d              = '0;
      out_d.power_on     = n_pwr;
      out_d.loops_on     = n_pwr;
      out_d.target_en    = n_oe || n_fra;
      out_d.stop_decel   = n_qs && !speed_zero;
      out_d.hold_pos     = n_qs && speed_zero && position_mode;
      out_d.hold_vel     = n_qs && speed_zero && !position_mode;
      out_d.homing_run   = n_home;
      out_d.inhibit_neg  = n_pwr && cw[`DCSM_B_INHIBIT_NEG];
      out_d.inhibit_pos  = n_pwr && cw[`DCSM_B_INHIBIT_POS];
      out_d.reaction_run = n_fra;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q     <= DCSM_START;
         cnt_q       <= '0;
         drive_out_q <= '0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         drive_out_q <= out_d;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   localparam int unsigned FRA_MAX = `DCSM_FRA_DWELL_MAX_CYC;

   sequence s_boot;
      (state_q == DCSM_START) ##1 (state_q == DCSM_NOT_READY)
         ##1 (state_q == DCSM_SW_ON_DIS);
   endsequence

   a_qs_entry: assert property (
      state_q == DCSM_OP_ENABLED && cmd_qstop && !en_lost && !fault_detect
      |=> state_q == DCSM_QSTOP ##1 drive_out_q.power_on)
      else $error("quick stop not entered");
   a_oe_shutdown: assert property (
      state_q == DCSM_OP_ENABLED && cmd_shutdown && !en_lost &&
      !fault_detect |=> state_q == DCSM_READY && !drive_out_q.power_on)
      else $error("shutdown from enabled failed");
   a_oe_disable: assert property (
      state_q == DCSM_OP_ENABLED && (cmd_dis_volt || en_lost) &&
      !fault_detect |=> state_q == DCSM_SW_ON_DIS)
      else $error("disable from enabled failed");
   a_oe_switchon: assert property (
      state_q == DCSM_OP_ENABLED && cmd_switchon && !en_lost &&
      !fault_detect |=> state_q == DCSM_SWITCHED && !drive_out_q.target_en)
      else $error("switch on from enabled failed");
   a_oe_running: assert property (
      state_q == DCSM_OP_ENABLED |-> drive_out_q.power_on &&
      drive_out_q.loops_on && drive_out_q.target_en)
      else $error("enabled without power or targets");
   a_qs_motion: assert property (
      state_q == DCSM_QSTOP |-> drive_out_q.power_on &&
      (drive_out_q.stop_decel != $past(speed_zero)))
      else $error("quick stop motion wrong");
   a_qs_enable: assert property (
      state_q == DCSM_QSTOP && cmd_enable && !en_lost && !fault_detect
      |=> state_q == DCSM_OP_ENABLED)
      else $error("re-enable from quick stop failed");
   a_qs_delay: assert property (
      state_q == DCSM_QSTOP && en_lost && !fault_detect
      |=> state_q == DCSM_PWR_DELAY)
      else $error("power delay skipped");
   a_fra_dwell: assert property (
      state_q == DCSM_FAULT && $past(state_q) == DCSM_FAULT_REACT
      |-> $past(cnt_q) == CNT_W'(FRA_CYC - 1) && FRA_CYC <= FRA_MAX)
      else $error("fault reaction dwell wrong");
   a_fra_power: assert property (
      state_q == DCSM_FAULT_REACT |-> drive_out_q.power_on &&
      drive_out_q.loops_on && drive_out_q.reaction_run)
      else $error("fault reaction without power");
   a_fault_dark: assert property (
      state_q == DCSM_FAULT |-> !drive_out_q.power_on &&
      !drive_out_q.loops_on)
      else $error("power on in fault");
   a_fault_exit: assert property (
      state_q == DCSM_FAULT && !cmd_rst_flt |=> state_q == DCSM_FAULT)
      else $error("fault left without reset");
   a_reset_edge: assert property (
      state_q == DCSM_FAULT && b7 && !$past(b7) |=> state_q == DCSM_SW_ON_DIS)
      else $error("reset fault edge missed");
   a_power_up: assert property (
      $fell(rst) |-> s_boot or (##2 state_q == DCSM_FAULT_REACT))
      else $error("power-up walk wrong");
   a_fault_entry: assert property (
      fault_detect && state_q == DCSM_SWITCHED |=> state_q == DCSM_FAULT_REACT
      ##1 drive_out_q.power_on)
      else $error("fault not taken");
   a_sod_hold: assert property (
      state_q == DCSM_SW_ON_DIS && !cmd_shutdown && !fault_detect
      |=> state_q == DCSM_SW_ON_DIS)
      else $error("undefined command moved state");
   a_ready_move: assert property (
      state_q == DCSM_READY && cmd_qstop && !fault_detect
      |=> state_q == DCSM_SW_ON_DIS)
      else $error("quick stop from ready failed");
   a_inhibit: assert property (
      drive_out_q.inhibit_neg |-> drive_out_q.power_on &&
      $past(cw[`DCSM_B_INHIBIT_NEG]))
      else $error("negative inhibit wrong");
   a_inhibit_pos: assert property (
      drive_out_q.inhibit_pos |-> drive_out_q.power_on &&
      $past(cw[`DCSM_B_INHIBIT_POS]))
      else $error("positive inhibit wrong");
   a_homing_run: assert property (
      state_q == DCSM_OP_ENABLED && homing_mode && b4 && cmd_enable &&
      !en_lost && !fault_detect |=> drive_out_q.homing_run)
      else $error("homing not started");
   a_sod_shutdown: assert property (
      state_q == DCSM_SW_ON_DIS && cmd_shutdown && !fault_detect
      |=> state_q == DCSM_READY)
      else $error("shutdown from disabled failed");
   a_sw_enable: assert property (
      state_q == DCSM_SWITCHED && cmd_enable && !fault_detect
      |=> state_q == DCSM_OP_ENABLED && drive_out_q.target_en)
      else $error("enable from switched on failed");
   a_qs_disable: assert property (
      state_q == DCSM_QSTOP && cmd_dis_volt && !fault_detect
      |=> state_q == DCSM_PWR_DELAY && drive_out_q.power_on)
      else $error("disable voltage skipped power delay");

endmodule // dcsm_top
`default_nettype wire

// [dcsm_defines.svh]
// Purpose: shared constants of the drive control state machine
// Assumes: 50 MHz drive clock
// Notes:   offsets-free block; the command word is a direct write port
`ifndef DCSM_DEFINES_SVH
`define DCSM_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCSM_CLK_PERIOD_NS     20
`define DCSM_FRA_DWELL_MIN_NS  100000
`define DCSM_FRA_DWELL_MAX_NS  2000000
// least time rounds up
`define DCSM_FRA_DWELL_CYC \
   ((`DCSM_FRA_DWELL_MIN_NS + `DCSM_CLK_PERIOD_NS - 1) / \
    `DCSM_CLK_PERIOD_NS)
// longest time rounds down
`define DCSM_FRA_DWELL_MAX_CYC (`DCSM_FRA_DWELL_MAX_NS / `DCSM_CLK_PERIOD_NS)
`define DCSM_PDD_CYC           100

// ----------------------------------------------------------------
// command word fields and reset value
// ----------------------------------------------------------------
`define DCSM_CMD_RESET         16'h0000
`define DCSM_B_SWITCH_ON       0
`define DCSM_B_VOLTAGE         1
`define DCSM_B_QSTOP_N         2
`define DCSM_B_ENABLE_OP       3
`define DCSM_B_HOMING          4
`define DCSM_B_FAULT_RESET     7
`define DCSM_B_INHIBIT_NEG     12
`define DCSM_B_INHIBIT_POS     13

`endif

// [dcsm_pkg.sv]
// Purpose: types of the drive control state machine
// Assumes: nothing beyond the defines header
// Notes:   one-hot state codes
`default_nettype none
package dcsm_pkg;

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [9:0] {
      DCSM_START      = 10'h001,
      DCSM_NOT_READY  = 10'h002,
      DCSM_SW_ON_DIS  = 10'h004,
      DCSM_READY      = 10'h008,
      DCSM_SWITCHED   = 10'h010,
      DCSM_OP_ENABLED = 10'h020,
      DCSM_QSTOP      = 10'h040,
      DCSM_PWR_DELAY  = 10'h080,
      DCSM_FAULT_REACT= 10'h100,
      DCSM_FAULT      = 10'h200
   } dcsm_state_t;

   // ----------------------------------------------------------------
   // drive controls towards power stage and loops
   // ----------------------------------------------------------------
   typedef struct packed {
      logic power_on;
      logic loops_on;
      logic target_en;
      logic stop_decel;
      logic hold_pos;
      logic hold_vel;
      logic homing_run;
      logic inhibit_neg;
      logic inhibit_pos;
      logic reaction_run;
   } dcsm_drive_out_t;

endpackage
`default_nettype wire

// [dcsm_master_model.sv]
// Purpose: network master model writing the drive command word
// Assumes: writes launched at the falling clock edge
// Notes:   data lines show the inverted word once the strobe drops
`timescale 1ns/1ps
`default_nettype none
module dcsm_master_model (
   input  wire logic        clk,
   output var  logic        cmd_wr,
   output var  logic [15:0] cmd_data
);
   initial begin
      cmd_wr   = 1'b0;
      cmd_data = 16'h0000;
   end

   // ----------------------------------------------------------------
   // one whole word per strobe, optionally after idle cycles
   // ----------------------------------------------------------------
   task automatic write_word(input logic [15:0] w, input int gap);
      repeat (gap) @(negedge clk);
      cmd_wr   = 1'b1;
      cmd_data = w;
      @(negedge clk);
      cmd_wr   = 1'b0;
      // released data must not pass for the last word
      cmd_data = ~w;
   endtask

   // bit 7 is seen low first, so the second write is a true rise
   task automatic reset_fault();
      write_word(16'h0000, 0);
      write_word(16'h0080, 2);
   endtask
endmodule // dcsm_master_model
`default_nettype wire

// [dcsm_top_tb.sv]
// Purpose: self-checking bench of the drive control state machine
// Assumes: short dwell and delay counts set by parameter
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ps
`default_nettype none
module dcsm_top_tb;
   import dcsm_pkg::*;
   localparam int unsigned FRA = 8;
   localparam int unsigned PDD = 4;
   logic            clk;
   logic            rst;
   logic            cmd_wr;
   logic [15:0]     cmd_data;
   logic            drive_enable_in;
   logic            fault_detect;
   logic            homing_mode;
   logic            position_mode;
   logic            speed_zero;
   dcsm_state_t     state_q;
   dcsm_drive_out_t drive_out_q;
   int              fails;
   int              n_tests;

   dcsm_top #(.FRA_CYC(FRA), .PDD_CYC(PDD), .CNT_W(17)) dut (
      .clk(clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
      .drive_enable_in(drive_enable_in), .fault_detect(fault_detect),
      .homing_mode(homing_mode), .position_mode(position_mode),
      .speed_zero(speed_zero), .state_q(state_q),
      .drive_out_q(drive_out_q));
   dcsm_master_model mst (.clk(clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data));

   initial clk = 1'b0;
   always #10 clk = ~clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk_st(input dcsm_state_t exp);
      n_tests++;
      if (state_q !== exp) begin
         fails++;
         $display("unexpected at %0t: state %h want %h", $time, state_q, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp, input string s);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s is %b", $time, s, got);
      end
   endtask

   // word acts one edge after the write edge
   task automatic wr(input logic [15:0] w);
      mst.write_word(w, 0);
      @(negedge clk);
   endtask

   task automatic wait_st(input dcsm_state_t exp, input int want);
      int n;
      n = 0;
      while (state_q !== exp && n < 50) begin
         @(negedge clk);
         n++;
      end
      n_tests++;
      if (n != want) begin
         fails++;
         $display("unexpected at %0t: %0d cycles, want %0d", $time, n, want);
      end
      if (n >= 50)
         report_and_stop();
   endtask

   task automatic go_oe();
      wr(16'h0006);
      chk_st(DCSM_READY);
      wr(16'h0007);
      chk_st(DCSM_SWITCHED);
      wr(16'h000f);
      chk_st(DCSM_OP_ENABLED);
      chk_b(drive_out_q.target_en, 1'b1, "target_en");
      chk_b(drive_out_q.power_on, 1'b1, "power_on");
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_boot();
      chk_b(drive_out_q.power_on, 1'b0, "power_on in reset");
      rst = 1'b0;
      @(negedge clk);
      chk_st(DCSM_NOT_READY);
      @(negedge clk);
      chk_st(DCSM_SW_ON_DIS);
      wr(16'h0007);
      chk_st(DCSM_SW_ON_DIS);
   endtask

   task automatic t_exits();
      go_oe();
      wr(16'h0007);
      chk_st(DCSM_SWITCHED);
      wr(16'h000f);
      wr(16'h0006);
      chk_st(DCSM_READY);
      wr(16'h0002);
      chk_st(DCSM_SW_ON_DIS);
      go_oe();
      wr(16'h001d);
      chk_st(DCSM_SW_ON_DIS);
      go_oe();
      drive_enable_in = 1'b0;
      @(negedge clk);
      chk_st(DCSM_SW_ON_DIS);
      drive_enable_in = 1'b1;
      wr(16'h0006);
      wr(16'h0007);
      wr(16'h001b);
      chk_st(DCSM_SW_ON_DIS);
   endtask

   task automatic t_qstop();
      go_oe();
      speed_zero = 1'b0;
      wr(16'h0002);
      chk_st(DCSM_QSTOP);
      chk_b(drive_out_q.stop_decel, 1'b1, "stop_decel");
      chk_b(drive_out_q.loops_on, 1'b1, "loops_on");
      speed_zero = 1'b1;
      repeat (2) @(negedge clk);
      chk_b(drive_out_q.hold_pos, 1'b1, "hold_pos");
      position_mode = 1'b0;
      repeat (2) @(negedge clk);
      chk_b(drive_out_q.hold_vel, 1'b1, "hold_vel");
      wr(16'h000f);
      chk_st(DCSM_OP_ENABLED);
      wr(16'h0002);
      wr(16'h0006);
      chk_st(DCSM_QSTOP);
      wr(16'h0000);
      chk_st(DCSM_PWR_DELAY);
      chk_b(drive_out_q.power_on, 1'b1, "power_on");
      wait_st(DCSM_SW_ON_DIS, PDD);
      go_oe();
      wr(16'h0002);
      drive_enable_in = 1'b0;
      @(negedge clk);
      chk_st(DCSM_PWR_DELAY);
      drive_enable_in = 1'b1;
      wait_st(DCSM_SW_ON_DIS, PDD);
   endtask

   task automatic t_fault();
      go_oe();
      fault_detect = 1'b1;
      @(negedge clk);
      fault_detect = 1'b0;
      chk_st(DCSM_FAULT_REACT);
      chk_b(drive_out_q.power_on, 1'b1, "power_on");
      chk_b(drive_out_q.reaction_run, 1'b1, "reaction_run");
      wait_st(DCSM_FAULT, FRA);
      chk_b(drive_out_q.power_on, 1'b0, "power_on");
      wr(16'h000f);
      chk_st(DCSM_FAULT);
      mst.reset_fault();
      @(negedge clk);
      chk_st(DCSM_SW_ON_DIS);
      wr(16'h0006);
      wr(16'h0007);
      chk_st(DCSM_SWITCHED);
      fault_detect = 1'b1;
      @(negedge clk);
      fault_detect = 1'b0;
      chk_st(DCSM_FAULT_REACT);
      wait_st(DCSM_FAULT, FRA);
      mst.reset_fault();
      @(negedge clk);
      chk_st(DCSM_SW_ON_DIS);
   endtask

   task automatic t_homing();
      homing_mode = 1'b1;
      go_oe();
      wr(16'h301f);
      chk_b(drive_out_q.homing_run, 1'b1, "homing_run");
      chk_b(drive_out_q.inhibit_neg, 1'b1, "inhibit_neg");
      chk_b(drive_out_q.inhibit_pos, 1'b1, "inhibit_pos");
      wr(16'h000f);
      chk_b(drive_out_q.homing_run, 1'b0, "homing_run");
      chk_b(drive_out_q.inhibit_neg, 1'b0, "inhibit_neg");
      homing_mode = 1'b0;
      wr(16'h001f);
      chk_b(drive_out_q.homing_run, 1'b0, "homing_run");
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst             = 1'b1;
      drive_enable_in = 1'b1;
      fault_detect    = 1'b0;
      homing_mode     = 1'b0;
      position_mode   = 1'b1;
      speed_zero      = 1'b0;
      fails           = 0;
      n_tests         = 0;
      repeat (20) @(negedge clk);
      t_boot();
      t_exits();
      t_qstop();
      t_fault();
      t_homing();
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop();
   end
endmodule // dcsm_top_tb
`default_nettype wire
